/* File: hdl/laser_shutdown_ctrl.sv */
// Automatic laser shutdown controller with APB register access.
// Assumes a 10 MHz clock, synchronous active-low reset, light pin async.
//
// Notes on behaviour
// - A control bit enables or disables automatic laser shutdown.
// - With shutdown disabled the laser stays on regardless of light.
// - Enabled and fibre cut: laser alternates between off and on periods.
// - Loss of signal declared after 550 ms of continuous absent light.
// - Declared loss with shutdown enabled turns our own laser off.
// - Automatic restart waits 60, 180 or 300 s after loss.
// - Automatic restart pulse keeps laser on for 2 s, then off.
// - Manual short restart with no light: laser on for 2 s.
// - Manual test restart with no light: laser on for 90 s.
// - Far end lights up on seeing light; returned light ends shutdown.
// - No light at end of a manual pulse: back to automatic restart.
// - Restart commands accepted only while maintenance is on.
module laser_shutdown_ctrl
    import laser_shutdown_pkg::*;
#(
    parameter int unsigned P_TICK_CYCLES = laser_shutdown_pkg::TICK_CYCLES
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [laser_shutdown_pkg::ADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_rx_light,
    output logic o_laser_on,
    output logic o_irq
);
    import laser_shutdown_pkg::*;

    apb_req_t req;
    ctrl_t ctrl_q;
    als_state_t state_q;
    als_state_t state_d;
    logic [EVT_W-1:0] evt_q;
    logic [EVT_W-1:0] mask_q;
    logic [EVT_W-1:0] ev_set;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic laser_q;
    logic irq_q;
    logic los_q;
    logic rx_ok;
    logic [MS_W-1:0] abs_ms;
    logic [MS_W-1:0] st_ms;
    logic [MS_W-1:0] intv_ms;
    logic apb_done;
    logic apb_wr;
    logic apb_rd;
    logic mapped;
    logic cmd_wr;
    logic cmd_short;
    logic cmd_test;
    logic cmd_ok;
    logic pulse_st;

    assign req = '{paddr: i_paddr, psel: i_psel, penable: i_penable,
                   pwrite: i_pwrite, pwdata: i_pwdata};

    rx_light_sync u_sync (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_pin(i_rx_light),
        .o_level(rx_ok)
    );

    // Absent-light duration, held at zero while light present
    ms_timer #(.P_TICK_CYCLES(P_TICK_CYCLES), .P_MS_W(MS_W)) u_abs_tmr (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_clear(rx_ok),
        .o_ms(abs_ms)
    );

    // Time spent in the current state
    ms_timer #(.P_TICK_CYCLES(P_TICK_CYCLES), .P_MS_W(MS_W)) u_st_tmr (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_clear(state_d != state_q),
        .o_ms(st_ms)
    );

    // APB slave: one wait state, answer on second access cycle
    assign apb_done = req.psel && req.penable && pready_q;
    assign apb_wr = apb_done && req.pwrite;
    assign apb_rd = apb_done && !req.pwrite;
    assign mapped = (req.paddr == CTRL_OFS) || (req.paddr == CMD_OFS) ||
                    (req.paddr == STATUS_OFS) || (req.paddr == EVT_OFS) ||
                    (req.paddr == MASK_OFS);

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= req.psel && req.penable && !pready_q;
            pslverr_q <= req.psel && req.penable && !pready_q && !mapped;
            prdata_q <= 32'h0000_0000;
            if (req.psel && req.penable && !pready_q && !req.pwrite) begin
                case (req.paddr)
                    CTRL_OFS: prdata_q <= {28'h0, ctrl_q};
                    STATUS_OFS: prdata_q <= {26'h0, state_q, laser_q,
                                             los_q, rx_ok};
                    EVT_OFS: prdata_q <= {28'h0, evt_q};
                    MASK_OFS: prdata_q <= {28'h0, mask_q};
                    default: prdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Control register
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            ctrl_q <= ctrl_t'(CTRL_RST);
        end else if (apb_wr && req.paddr == CTRL_OFS) begin
            ctrl_q <= ctrl_t'(req.pwdata[3:0]);
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            mask_q <= MASK_RST;
        end else if (apb_wr && req.paddr == MASK_OFS) begin
            mask_q <= req.pwdata[EVT_W-1:0];
        end
    end

    // Loss-of-signal detection
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            los_q <= 1'b0;
        end else if (rx_ok) begin
            los_q <= 1'b0;
        end else if (abs_ms == LOS_MS) begin
            los_q <= 1'b1;
        end
    end

    // Restart commands
    assign cmd_wr = apb_wr && req.paddr == CMD_OFS;
    assign cmd_short = cmd_wr && req.pwdata[CMD_SHORT_BIT];
    assign cmd_test = cmd_wr && req.pwdata[CMD_TEST_BIT];
    assign cmd_ok = ctrl_q.maint_on && !rx_ok && state_q == ST_SHUT;
    assign pulse_st = state_q == ST_AUTO || state_q == ST_MAN ||
                      state_q == ST_TEST;

    always_comb begin
        case (ctrl_q.intv_sel)
            INTV_60: intv_ms = AUTO_60_MS;
            INTV_180: intv_ms = AUTO_180_MS;
            default: intv_ms = AUTO_300_MS;
        endcase
    end

    // Shutdown state machine
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_NORMAL: begin
                if (ctrl_q.als_en && los_q) begin
                    state_d = ST_SHUT;
                end
            end
            ST_SHUT: begin
                if (!ctrl_q.als_en || rx_ok) begin
                    state_d = ST_NORMAL;
                end else if (cmd_test && cmd_ok) begin
                    state_d = ST_TEST;
                end else if (cmd_short && cmd_ok) begin
                    state_d = ST_MAN;
                end else if (st_ms == intv_ms) begin
                    state_d = ST_AUTO;
                end
            end
            ST_AUTO: begin
                if (!ctrl_q.als_en || rx_ok) begin
                    state_d = ST_NORMAL;
                end else if (st_ms == RESTART_MS) begin
                    state_d = ST_SHUT;
                end
            end
            ST_MAN: begin
                if (!ctrl_q.als_en || rx_ok) begin
                    state_d = ST_NORMAL;
                end else if (st_ms == RESTART_MS) begin
                    state_d = ST_SHUT;
                end
            end
            ST_TEST: begin
                if (!ctrl_q.als_en || rx_ok) begin
                    state_d = ST_NORMAL;
                end else if (st_ms == TEST_MS) begin
                    state_d = ST_SHUT;
                end
            end
            default: state_d = ST_NORMAL;
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            state_q <= ST_NORMAL;
        end else begin
            state_q <= state_d;
        end
    end

    // Laser drive follows the next state, so it matches state_q
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            laser_q <= 1'b1;
        end else begin
            laser_q <= state_d != ST_SHUT;
        end
    end

    // Sticky events, cleared by read; a new event wins over the clear
    always_comb begin
        ev_set = '0;
        ev_set[EVT_LOS_BIT] = !rx_ok && !los_q && abs_ms == LOS_MS;
        ev_set[EVT_REC_BIT] = pulse_st && state_d == ST_NORMAL && rx_ok;
        ev_set[EVT_PULSE_BIT] = state_q == ST_SHUT &&
                                state_d != ST_SHUT && state_d != ST_NORMAL;
        ev_set[EVT_REFUSE_BIT] = (cmd_short || cmd_test) && !cmd_ok;
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            evt_q <= EVT_RST;
        end else if (apb_rd && req.paddr == EVT_OFS) begin
            evt_q <= ev_set;
        end else begin
            evt_q <= evt_q | ev_set;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(evt_q & mask_q);
        end
    end

    assign o_prdata = prdata_q;
    assign o_pready = pready_q;
    assign o_pslverr = pslverr_q;
    assign o_laser_on = laser_q;
    assign o_irq = irq_q;

    // Checks
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_n);

    sequence seq_ctrl_write;
        apb_wr && req.paddr == CTRL_OFS;
    endsequence

    sequence seq_refused_cmd;
        cmd_wr && (req.pwdata[CMD_SHORT_BIT] || req.pwdata[CMD_TEST_BIT]) &&
        (!ctrl_q.maint_on || rx_ok);
    endsequence

    sequence seq_leave(als_state_t s);
        state_q == s && state_d == ST_SHUT;
    endsequence

    AST_CTRL_WRITE: assert property (
        seq_ctrl_write |=> ctrl_q == $past(req.pwdata[3:0]))
        else $error("control write not stored");

    AST_DISABLED_ON: assert property (
        !ctrl_q.als_en |=> o_laser_on [*2])
        else $error("laser off while shutdown disabled");

    AST_SHUT_OFF: assert property (
        state_q == ST_SHUT |-> !o_laser_on)
        else $error("laser on during shutdown wait");

    AST_LOS_TIME: assert property (
        $rose(los_q) |-> $past(abs_ms) == LOS_MS && $past(!rx_ok))
        else $error("loss declared at wrong time");

    AST_LOS_SHUT: assert property (
        state_q == ST_NORMAL && los_q && ctrl_q.als_en && !rx_ok
        |=> state_q == ST_SHUT ##0 !o_laser_on)
        else $error("laser not cut on loss");

    AST_AUTO_WAIT: assert property (
        state_q == ST_SHUT && state_d == ST_AUTO |-> st_ms == intv_ms)
        else $error("restart interval wrong");

    AST_AUTO_LEN: assert property (
        seq_leave(ST_AUTO) |-> st_ms == RESTART_MS && o_laser_on)
        else $error("automatic pulse length wrong");

    AST_MAN_LEN: assert property (
        seq_leave(ST_MAN) |-> st_ms == RESTART_MS)
        else $error("manual pulse length wrong");

    AST_TEST_LEN: assert property (
        seq_leave(ST_TEST) |-> st_ms == TEST_MS)
        else $error("test pulse length wrong");

    AST_RECOVER: assert property (
        pulse_st && rx_ok |=> state_q == ST_NORMAL && o_laser_on)
        else $error("light returned but shutdown kept");

    AST_FALLBACK: assert property (
        (state_q == ST_MAN || state_q == ST_TEST) && state_d != state_q &&
        !rx_ok && ctrl_q.als_en |=> state_q == ST_SHUT)
        else $error("no fallback to automatic restart");

    AST_MAINT_ONLY: assert property (
        seq_refused_cmd ##0 state_q == ST_SHUT
        |=> state_q != ST_MAN && state_q != ST_TEST)
        else $error("command taken without maintenance or with light");

    AST_REFUSE_FLAG: assert property (
        seq_refused_cmd |=> evt_q[EVT_REFUSE_BIT])
        else $error("refused command not flagged");

endmodule : laser_shutdown_ctrl

/* File: hdl/laser_shutdown_pkg.sv */
// Package for the automatic laser shutdown controller.
// Assumes a 10 MHz system clock and a 32-bit APB register bus.
package laser_shutdown_pkg;

    // Clock and tick timing
    localparam int unsigned MCLK_PERIOD_NS = 100;
    localparam int unsigned TICK_PERIOD_NS = 1000000;
    localparam int unsigned TICK_CYCLES = TICK_PERIOD_NS / MCLK_PERIOD_NS;

    // Interval figures, in milliseconds
    localparam int unsigned MS_W = 19;
    localparam logic [18:0] LOS_MS = 19'd550;
    localparam logic [18:0] RESTART_MS = 19'd2000;
    localparam logic [18:0] TEST_MS = 19'd90000;
    localparam logic [18:0] AUTO_60_MS = 19'd60000;
    localparam logic [18:0] AUTO_180_MS = 19'd180000;
    localparam logic [18:0] AUTO_300_MS = 19'd300000;

    // Register offsets (byte addresses)
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] CMD_OFS = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;
    localparam logic [7:0] EVT_OFS = 8'h0C;
    localparam logic [7:0] MASK_OFS = 8'h10;

    // Control fields
    localparam int unsigned CTRL_ALS_EN_BIT = 0;
    localparam int unsigned CTRL_MAINT_BIT = 1;
    localparam int unsigned CTRL_INTV_LSB = 2;
    localparam logic [3:0] CTRL_RST = 4'h1;

    // Command fields
    localparam int unsigned CMD_SHORT_BIT = 0;
    localparam int unsigned CMD_TEST_BIT = 1;

    // Interval select codes
    localparam logic [1:0] INTV_60 = 2'h0;
    localparam logic [1:0] INTV_180 = 2'h1;

    // Event fields
    localparam int unsigned EVT_W = 4;
    localparam int unsigned EVT_LOS_BIT = 0;
    localparam int unsigned EVT_REC_BIT = 1;
    localparam int unsigned EVT_PULSE_BIT = 2;
    localparam int unsigned EVT_REFUSE_BIT = 3;
    localparam logic [3:0] EVT_RST = 4'h0;
    localparam logic [3:0] MASK_RST = 4'h0;

    typedef struct packed {
        logic [1:0] intv_sel;
        logic maint_on;
        logic als_en;
    } ctrl_t;

    typedef struct packed {
        logic [7:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef enum logic [2:0] {
        ST_NORMAL = 3'b000,
        ST_SHUT = 3'b001,
        ST_AUTO = 3'b010,
        ST_MAN = 3'b011,
        ST_TEST = 3'b100
    } als_state_t;

endpackage : laser_shutdown_pkg

/* File: hdl/rx_light_sync.sv */
// Three-stage synchroniser with agreement filter for the light input.
// Assumes an asynchronous pin; output changes once stages two and three agree.
module rx_light_sync (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_pin,
    output logic o_level
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic level_q;

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= i_pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            level_q <= 1'b0;
        end else if (s2_q == s3_q) begin
            level_q <= s3_q;
        end
    end

    assign o_level = level_q;
endmodule : rx_light_sync

/* File: hdl/ms_timer.sv */
// Millisecond counter: prescaler plus saturating count of ticks.
// Assumes a synchronous clear from logic on the same clock.
module ms_timer #(
    parameter int unsigned P_TICK_CYCLES = 10000,
    parameter int unsigned P_MS_W = 19
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_clear,
    output logic [P_MS_W-1:0] o_ms
);
    localparam int unsigned PW = $clog2(P_TICK_CYCLES + 1);
    localparam logic [PW-1:0] PRE_LAST = PW'(P_TICK_CYCLES - 1);

    logic [PW-1:0] pre_q;
    logic [P_MS_W-1:0] ms_q;

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n || i_clear) begin
            pre_q <= '0;
            ms_q <= '0;
        end else if (pre_q == PRE_LAST) begin
            pre_q <= '0;
            if (ms_q != '1) begin
                ms_q <= ms_q + 1'b1;
            end
        end else begin
            pre_q <= pre_q + 1'b1;
        end
    end

    assign o_ms = ms_q;
endmodule : ms_timer

/* File: tb/far_end_mux.sv */
// Far-end multiplexer optical port model.
// Assumes the bench breaks the block's receive path through i_path_ok.
module far_end_mux (
    input wire logic i_mclk,
    input wire logic i_laser_on,
    input wire logic i_path_ok,
    input wire logic [7:0] i_on_dly,
    output logic o_light
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int LOS_CYC = 100;
    int lit_cnt = 0;
    int dark_cnt = 0;
    logic far_laser = 1'b0;

    // Own laser follows received light, with prompt or slow turn-on
    always @(posedge i_mclk) begin
        if (i_laser_on) begin
            dark_cnt <= 0;
            lit_cnt <= lit_cnt + 1;
            if (lit_cnt >= int'(i_on_dly)) begin
                far_laser <= 1'b1;
            end
        end else begin
            lit_cnt <= 0;
            dark_cnt <= dark_cnt + 1;
            if (dark_cnt >= LOS_CYC) begin
                far_laser <= 1'b0;
            end
        end
    end

    assign o_light = far_laser & i_path_ok;
endmodule : far_end_mux

/* File: tb/optical_laser_shutdown_ctrl_bench.sv */
// Bench for the laser shutdown controller and a far-end model.
// Assumes a 10 MHz clock and a one-clock millisecond tick.
`define CHK(a, b) \
    begin n_compared++; if ((a) !== (b)) begin failures++; \
    $display("ERROR %0t: got %h exp %h", $time, (a), (b)); end end
module optical_laser_shutdown_ctrl_bench;
    import laser_shutdown_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int T = 1;
    logic i_mclk = 1'b0;
    logic i_rst_n = 1'b0;
    apb_req_t req = '0;
    logic [31:0] o_prdata;
    logic o_pready, o_pslverr, o_laser_on, o_irq, rx_light, err;
    logic path_ok = 1'b1;
    logic [7:0] on_dly = 8'h04;
    int failures = 0;
    int n_compared = 0;
    int seed = 32'h164B;
    int exp_evt = 0;
    int cyc;
    logic [31:0] rd, rnd;

    always #50 i_mclk = ~i_mclk;

    laser_shutdown_ctrl #(.P_TICK_CYCLES(T)) laser_shutdown_ctrl_i (
        .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_psel(req.psel),
        .i_penable(req.penable), .i_pwrite(req.pwrite),
        .i_paddr(req.paddr), .i_pwdata(req.pwdata), .o_prdata(o_prdata),
        .o_pready(o_pready), .o_pslverr(o_pslverr),
        .i_rx_light(rx_light), .o_laser_on(o_laser_on), .o_irq(o_irq));

    far_end_mux far_end_mux_i (.i_mclk(i_mclk), .i_laser_on(o_laser_on),
        .i_path_ok(path_ok), .i_on_dly(on_dly), .o_light(rx_light));

    task automatic test_done;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : test_done

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_mclk);
        req <= '{a, 1'b1, 1'b0, wr, d};
        @(posedge i_mclk);
        req.penable <= 1'b1;
        do begin
            @(posedge i_mclk);
            n++;
        end while (o_pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            failures++;
            test_done();
        end
        rd = o_prdata;
        err = o_pslverr;
        req <= '0;
    endtask : apb

    task automatic wait_laser(input logic v, input int lim);
        cyc = 0;
        while (o_laser_on !== v) begin
            @(posedge i_mclk);
            cyc++;
            if (cyc > lim) begin
                failures++;
                test_done();
            end
        end
    endtask : wait_laser

    initial begin
        rnd = $random(seed);
        on_dly = 8'(1 + (rnd[7:0] % 8'd20));
        repeat (8) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        @(posedge i_mclk);
        `CHK(o_laser_on, 1'b1)
        `CHK(o_irq, 1'b0)
        apb(1'b0, CTRL_OFS, 32'h0);
        `CHK(rd, 32'h1)
        apb(1'b0, MASK_OFS, 32'h0);
        `CHK(rd, 32'h0)
        apb(1'b0, 8'h14, 32'h0);
        `CHK({err, rd}, {1'b1, 32'h0})
        rnd = $random(seed);
        apb(1'b1, CTRL_OFS, {rnd[31:4], 4'h9});
        apb(1'b0, CTRL_OFS, 32'h0);
        `CHK(rd, 32'h9)
        apb(1'b1, CTRL_OFS, 32'h1);
        repeat (50) @(posedge i_mclk);
        apb(1'b0, STATUS_OFS, 32'h0);
        `CHK(rd[5:0], 6'h05)
        // Command with maintenance off, first masked
        apb(1'b1, CMD_OFS, 32'h1);
        exp_evt |= 8;
        repeat (3) @(posedge i_mclk);
        `CHK(o_irq, 1'b0)
        apb(1'b1, MASK_OFS, 32'hF);
        repeat (3) @(posedge i_mclk);
        `CHK(o_irq, 1'b1)
        apb(1'b0, EVT_OFS, 32'h0);
        `CHK(rd, 32'(exp_evt))
        exp_evt = 0;
        repeat (3) @(posedge i_mclk);
        `CHK(o_irq, 1'b0)
        // Maintenance on, light present
        apb(1'b1, CTRL_OFS, 32'h3);
        apb(1'b1, CMD_OFS, 32'h1);
        exp_evt |= 8;
        apb(1'b0, EVT_OFS, 32'h0);
        `CHK(rd, 32'(exp_evt))
        `CHK(o_laser_on, 1'b1)
        // Shutdown disabled, fibre cut
        apb(1'b1, CTRL_OFS, 32'h2);
        path_ok <= 1'b0;
        repeat (700 * T) @(posedge i_mclk);
        `CHK(o_laser_on, 1'b1)
        path_ok <= 1'b1;
        repeat (50) @(posedge i_mclk);
        apb(1'b1, CTRL_OFS, 32'h3);
        apb(1'b0, EVT_OFS, 32'h0);
        exp_evt = 0;
        // Loss of signal then manual short restart
        @(posedge i_mclk);
        path_ok <= 1'b0;
        wait_laser(1'b0, 700 * T);
        `CHK(cyc >= 550 * T && cyc <= 550 * T + 15, 1'b1)
        exp_evt |= 1;
        rnd = $random(seed);
        apb(1'b1, CMD_OFS, {rnd[31:2], 2'h1});
        wait_laser(1'b1, 10);
        wait_laser(1'b0, 2100 * T);
        `CHK(cyc >= 2000 * T - 3 && cyc <= 2000 * T + 3, 1'b1)
        exp_evt |= 4;
        // Far end goes dark first, then fibre mended; auto pulse recovers
        repeat (200) @(posedge i_mclk);
        path_ok <= 1'b1;
        wait_laser(1'b1, 60100 * T);
        `CHK(cyc >= 60000 * T - 210 && cyc <= 60000 * T - 190, 1'b1)
        `CHK(cyc > 200, 1'b1)
        exp_evt |= 6;
        repeat (2200 * T) @(posedge i_mclk);
        `CHK(o_laser_on, 1'b1)
        apb(1'b0, STATUS_OFS, 32'h0);
        `CHK(rd[5:0], 6'h05)
        apb(1'b0, EVT_OFS, 32'h0);
        `CHK(rd, 32'(exp_evt))
        exp_evt = 0;
        // Test restart, both command bits set
        path_ok <= 1'b0;
        wait_laser(1'b0, 700 * T);
        exp_evt |= 1;
        apb(1'b1, CMD_OFS, 32'h3);
        wait_laser(1'b1, 10);
        exp_evt |= 4;
        repeat (3000 * T) @(posedge i_mclk);
        `CHK(o_laser_on, 1'b1)
        apb(1'b0, STATUS_OFS, 32'h0);
        `CHK(rd[5:3], 3'h4)
        apb(1'b1, CMD_OFS, 32'h1);
        exp_evt |= 8;
        path_ok <= 1'b1;
        exp_evt |= 2;
        repeat (200) @(posedge i_mclk);
        apb(1'b0, STATUS_OFS, 32'h0);
        `CHK(rd[5:0], 6'h05)
        apb(1'b0, EVT_OFS, 32'h0);
        `CHK(rd, 32'(exp_evt))
        test_done();
    end
endmodule : optical_laser_shutdown_ctrl_bench
